// ==== rtl/pvlan_flood.sv ====
`timescale 1ns/1ps
module pvlan_flood (
	input  wire logic [vlan_filter_pkg::PORT_W-1:0]                       in_port,     // Ingress port.
	input  wire vlan_filter_pkg::port_class_t [vlan_filter_pkg::MAX_PORTS-1:0] cls,   // Effective class per port.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0][vlan_filter_pkg::SEC_W-1:0] grp, // Secondary group per port.
	input  wire logic [vlan_filter_pkg::NUM_SEC-1:0][vlan_filter_pkg::MAX_PORTS-1:0] map_mask, // Group to primaries.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0]                    port_en,     // Ports that exist.
	input  wire logic                                                     admit,       // Outside flood admitted.
	output logic      [vlan_filter_pkg::MAX_PORTS-1:0]                    flood_mask   // Flood destinations.
);
	import vlan_filter_pkg::*;

	port_class_t       c_in;
	logic [SEC_W-1:0]  g_in;

	assign c_in = cls[in_port];
	assign g_in = grp[in_port];

	for (genvar p = 0; p < MAX_PORTS; p++) begin : g_port
		logic member;
		logic hit;
		assign member = (cls[p] == PC_ISOLATED) || (cls[p] == PC_COMMUNITY);
		always_comb begin
			hit = 1'b0;
			case (c_in)
				PC_ISOLATED:  hit = (cls[p] == PC_PRIMARY) && map_mask[g_in][p]; // RULE12
				PC_COMMUNITY: hit = ((cls[p] == PC_PRIMARY) && map_mask[g_in][p]) ||
				                    ((cls[p] == PC_COMMUNITY) && (grp[p] == g_in)); // RULE13
				// A primary reaches its mapped members, but only when this flood class is admitted.
				PC_PRIMARY:   hit = member ? (admit && map_mask[grp[p]][in_port]) : 1'b1; // RULE14 RULE15 RULE20
				PC_NONE:      hit = !member; // RULE15
				default:      hit = 1'b0;
			endcase
			flood_mask[p] = hit && port_en[p] && (PORT_W'(p) != in_port);
		end
	end

endmodule

// ==== rtl/vlan_filter_pkg.sv ====
// Functional notes
// [RULE1] Setting an outer tag type on one port sets it on its whole port group.
// [RULE2] Clearing the outer tag type on one port clears its whole port group.
// [RULE3] On gigabit modules the first two ports always share one port group.
// [RULE4] Group size follows module: per port, per ten ports or per twenty ports.
// [RULE5] Outer tag type is sixteen bits, any value, reset value 8100 hex.
// [RULE6] Management must program a value other than 8100 on the core link.
// [RULE7] A configured port in a multi-slot trunk spreads the value to all trunk members.
// [RULE8] A configuration naming no port applies to every port.
// [RULE9] Management should give all multi-slot trunk members one tag type.
// [RULE10] Tagged ingress with matching type: strip it, push the uplink type on egress.
// [RULE11] Untagged ingress: keep existing tag as payload, push the uplink outer tag.
// [RULE12] Floods from an isolated port reach only the mapped primary ports.
// [RULE13] Floods from a community port reach primary ports and same-community ports.
// [RULE14] Primary ports reach every isolated and community port mapped to them.
// [RULE15] Outside floods are blocked from members unless their class is admitted; code admits only floods from primary ports, never from PC_NONE ports.
// [RULE16] Management gives each private group exactly one primary group.
// [RULE17] Address lookup may hold one MAC in several VLANs; treated as normal.
// [RULE18] Edge variant with mappings enabled hands all flooded frames to software.
// [RULE19] Edge variant refuses private membership on tagged ports.
// [RULE20] Edge variant: all primary ports active, mappings choose which are used.
// [RULE21] Dual-mode ports are never accepted as private members.
// [RULE22] Known unicast goes straight to its learned port, even inside a private group.
// [RULE23] The field after the source address is tagged only if it equals the port type.
// [RULE24] Per-port class and per-group primary mapping are used on every flood.
package vlan_filter_pkg;

	localparam int          MAX_PORTS         = 16;
	localparam int          PORT_W            = 4;
	localparam int          NUM_SEC           = 4;
	localparam int          SEC_W             = 2;
	localparam int          TAG_W             = 16;
	localparam int          TEN_PORT_BLOCK    = 10;
	localparam int          TWENTY_PORT_BLOCK = 20;
	localparam logic [15:0] TAG_RESET         = 16'h8100;

	typedef enum logic [1:0] {
		PC_NONE      = 2'b00,
		PC_PRIMARY   = 2'b01,
		PC_ISOLATED  = 2'b10,
		PC_COMMUNITY = 2'b11
	} port_class_t;

	typedef enum logic [1:0] {
		GRAN_PER_PORT = 2'b00,
		GRAN_PER_10   = 2'b01,
		GRAN_PER_20   = 2'b10
	} tag_gran_t;

	typedef struct packed {
		logic              valid;
		logic              clear;
		logic              all_ports;
		logic [PORT_W-1:0] port;
		logic [TAG_W-1:0]  tag;
	} tag_cfg_t;

	typedef struct packed {
		logic              valid;
		logic [PORT_W-1:0] in_port;
		logic [TAG_W-1:0]  type_field;
		logic              bcast;
		logic              unknown_uc;
		logic              unknown_mc;
		logic [PORT_W-1:0] known_port;
	} frame_hdr_t;

	typedef struct packed {
		logic                 valid;
		logic [MAX_PORTS-1:0] egress;
		logic                 to_cpu;
		logic                 strip_outer;
		logic                 push_outer;
		logic [TAG_W-1:0]     outer_tag;
		logic [TAG_W-1:0]     ingress_tag;
	} fwd_decision_t;

endpackage

// ==== rtl/vlan_tag_pvlan_filter.sv ====
`timescale 1ns/1ps
module vlan_tag_pvlan_filter #(
	parameter int NUM_PORTS = 16
) (
	input  wire logic                                                 core_clk,     // 40 MHz clock.
	input  wire logic                                                 rst_b,        // Synchronous reset, low.
	input  wire vlan_filter_pkg::tag_gran_t                           tag_gran,     // Module tag granularity.
	input  wire vlan_filter_pkg::tag_cfg_t                            tag_cfg,      // Tag type write.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0]                trunk_member, // Multi-slot trunk ports.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0]                port_tagged,  // Port is tagged.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0]                dual_mode,    // Port in dual mode.
	input  wire logic [vlan_filter_pkg::PORT_W-1:0]                   uplink_port,  // Provider uplink port.
	input  wire vlan_filter_pkg::port_class_t [vlan_filter_pkg::MAX_PORTS-1:0] port_class, // Configured class.
	input  wire logic [vlan_filter_pkg::MAX_PORTS-1:0][vlan_filter_pkg::SEC_W-1:0] sec_group, // Group per port.
	input  wire logic [vlan_filter_pkg::NUM_SEC-1:0][vlan_filter_pkg::MAX_PORTS-1:0] sec_map, // Group to primaries.
	input  wire logic                                                 admit_bcast,  // Admit outside broadcast.
	input  wire logic                                                 admit_uu,     // Admit outside unknown uc.
	input  wire logic                                                 edge_variant, // Edge switch behaviour.
	input  wire vlan_filter_pkg::frame_hdr_t                          frame_hdr,    // Frame header in.
	output logic      [vlan_filter_pkg::MAX_PORTS-1:0][vlan_filter_pkg::TAG_W-1:0] tag_table, // Tag per port.
	output logic      [vlan_filter_pkg::MAX_PORTS-1:0]                member_reject, // Refused membership.
	output vlan_filter_pkg::fwd_decision_t                            decision      // Forwarding decision.
);
	import vlan_filter_pkg::*;

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (NUM_PORTS < 2 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
		$error("NUM_PORTS must lie between 2 and MAX_PORTS");
	end

	// ------------------------------------------------------------------
	// Port groups
	// ------------------------------------------------------------------
	function automatic logic [PORT_W-1:0] group_of(input logic [PORT_W-1:0] p, input tag_gran_t g);
		logic [PORT_W-1:0] r;
		r = p;
		case (g)
			GRAN_PER_10:   r = PORT_W'(int'(p) / TEN_PORT_BLOCK);    // RULE4 RULE3
			GRAN_PER_20:   r = PORT_W'(int'(p) / TWENTY_PORT_BLOCK); // RULE4 RULE3
			default:       r = p;                                    // RULE4
		endcase
		return r;
	endfunction

	logic [MAX_PORTS-1:0] port_en;
	logic [MAX_PORTS-1:0] cfg_hit;

	for (genvar p = 0; p < MAX_PORTS; p++) begin : g_hit
		assign port_en[p] = (p < NUM_PORTS);
		// A write lands on the named port's group, on its trunk partners, or everywhere.
		assign cfg_hit[p] = port_en[p] && (tag_cfg.all_ports || // RULE8
		                    (group_of(PORT_W'(p), tag_gran) == group_of(tag_cfg.port, tag_gran)) || // RULE1 RULE2
		                    (trunk_member[p] && trunk_member[tag_cfg.port])); // RULE7
	end

	// ------------------------------------------------------------------
	// Tag type table
	// ------------------------------------------------------------------
	// One entry per port keeps lookup trivial; a write hits the named port's whole group, but trunk partners are written alone.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < MAX_PORTS; i++) begin
				tag_table[i] <= TAG_RESET; // RULE5
			end
		end else if (tag_cfg.valid) begin
			for (int i = 0; i < MAX_PORTS; i++) begin
				if (cfg_hit[i]) begin
					tag_table[i] <= tag_cfg.clear ? TAG_RESET : tag_cfg.tag; // RULE1 RULE2 RULE5
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Effective port class
	// ------------------------------------------------------------------
	port_class_t [MAX_PORTS-1:0] eff_class;
	logic        [MAX_PORTS-1:0] refuse;
	logic        [MAX_PORTS-1:0] primary_mask;
	logic        [MAX_PORTS-1:0] member_mask;

	for (genvar p = 0; p < MAX_PORTS; p++) begin : g_class
		assign refuse[p] = dual_mode[p] || (edge_variant && port_tagged[p]); // RULE19 RULE21
		assign eff_class[p] = (refuse[p] || !port_en[p]) ? PC_NONE : port_class[p]; // RULE24
		assign primary_mask[p] = (eff_class[p] == PC_PRIMARY);
		assign member_mask[p] = (eff_class[p] == PC_ISOLATED) || (eff_class[p] == PC_COMMUNITY);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			member_reject <= '0;
		end else begin
			for (int i = 0; i < MAX_PORTS; i++) begin
				member_reject[i] <= refuse[i] && (port_class[i] != PC_NONE) && port_en[i]; // RULE19 RULE21
			end
		end
	end

	// ------------------------------------------------------------------
	// Flood and forward decision
	// ------------------------------------------------------------------
	logic                 is_flood;
	logic                 pvlan_on;
	logic                 admit;
	logic                 in_tagged;
	logic [MAX_PORTS-1:0] flood_mask;
	logic [MAX_PORTS-1:0] next_egress;
	logic                 next_to_cpu;

	assign is_flood  = frame_hdr.bcast || frame_hdr.unknown_uc || frame_hdr.unknown_mc;
	assign pvlan_on  = |sec_map;
	// Unknown multicast follows the broadcast setting; only unknown unicast has its own.
	assign admit     = frame_hdr.unknown_uc ? admit_uu : admit_bcast; // RULE15
	assign in_tagged = port_tagged[frame_hdr.in_port] &&
	                   (frame_hdr.type_field == tag_table[frame_hdr.in_port]); // RULE23

	pvlan_flood u_flood (
		.in_port    (frame_hdr.in_port),
		.cls        (eff_class),
		.grp        (sec_group),
		.map_mask   (sec_map),
		.port_en    (port_en),
		.admit      (admit),
		.flood_mask (flood_mask)
	);

	always_comb begin
		next_egress = '0;
		next_to_cpu = 1'b0;
		if (is_flood && edge_variant && pvlan_on) begin
			next_to_cpu = 1'b1; // RULE18
		end else if (is_flood) begin
			next_egress = flood_mask; // RULE24
		end else if (frame_hdr.known_port != frame_hdr.in_port) begin
			// The lookup feeding known_port may keep one MAC per VLAN; the port it gives is trusted.
			next_egress = port_en & (MAX_PORTS'(1) << frame_hdr.known_port); // RULE22 RULE17
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			decision <= '0;
		end else begin
			decision.valid       <= frame_hdr.valid;
			decision.egress      <= frame_hdr.valid ? next_egress : '0;
			decision.to_cpu      <= frame_hdr.valid && next_to_cpu;
			decision.ingress_tag <= tag_table[frame_hdr.in_port];
			decision.outer_tag   <= tag_table[uplink_port]; // RULE10 RULE11
			if (frame_hdr.valid && next_egress[uplink_port] && (frame_hdr.in_port != uplink_port)) begin
				decision.push_outer  <= 1'b1;      // RULE10 RULE11
				decision.strip_outer <= in_tagged; // RULE10 RULE11
			end else begin
				decision.push_outer  <= 1'b0;
				decision.strip_outer <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic [MAX_PORTS-1:0] prev_primary;
	logic [MAX_PORTS-1:0] prev_member;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prev_primary <= '0;
			prev_member  <= '0;
		end else begin
			prev_primary <= primary_mask;
			prev_member  <= member_mask;
		end
	end

	// Expected masks are rebuilt from the class and mapping inputs, not taken from the flood unit.
	logic [MAX_PORTS-1:0] to_primary;
	logic [MAX_PORTS-1:0] peer_mask;
	logic [MAX_PORTS-1:0] reach_mask;
	logic [MAX_PORTS-1:0] dual_claim;
	logic [MAX_PORTS-1:0] edge_claim;

	for (genvar p = 0; p < MAX_PORTS; p++) begin : g_watch
		assign to_primary[p] = primary_mask[p] && sec_map[sec_group[frame_hdr.in_port]][p];
		assign peer_mask[p]  = (eff_class[p] == PC_COMMUNITY) && (PORT_W'(p) != frame_hdr.in_port) &&
		                       (sec_group[p] == sec_group[frame_hdr.in_port]);
		assign reach_mask[p] = member_mask[p] && sec_map[sec_group[p]][frame_hdr.in_port];
		assign dual_claim[p] = port_en[p] && (port_class[p] != PC_NONE) && dual_mode[p];
		assign edge_claim[p] = port_en[p] && (port_class[p] != PC_NONE) && edge_variant && port_tagged[p];
	end

	a_all_ports_write: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
		tag_cfg.valid && !tag_cfg.clear && tag_cfg.all_ports
		|=> tag_table[NUM_PORTS-1] == $past(tag_cfg.tag) && tag_table[0] == $past(tag_cfg.tag))
		else $error("write without port did not reach all ports");

	a_group_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
		tag_cfg.valid && tag_cfg.clear && tag_gran == GRAN_PER_10 && tag_cfg.port < 4'ha
		|=> tag_table[9] == TAG_RESET && tag_table[0] == TAG_RESET)
		else $error("clear did not reach whole port group");

	a_group_spread: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
		tag_cfg.valid && !tag_cfg.clear && !tag_cfg.all_ports && tag_gran == GRAN_PER_10 &&
		tag_cfg.port == 4'h3 && !trunk_member[10]
		|=> tag_table[0] == $past(tag_cfg.tag) && tag_table[9] == $past(tag_cfg.tag) &&
		    tag_table[10] == $past(tag_table[10]))
		else $error("group write wrong extent");

	a_gig_pair_equal: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
		tag_cfg.valid && tag_gran != GRAN_PER_PORT && tag_cfg.port < 4'ha
		|=> tag_table[0] == tag_table[1])
		else $error("first two gigabit ports differ");

	a_trunk_spread: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
		tag_cfg.valid && !tag_cfg.clear && trunk_member[tag_cfg.port] && trunk_member[NUM_PORTS-1]
		|=> tag_table[NUM_PORTS-1] == $past(tag_cfg.tag))
		else $error("trunk member missed tag write");

	a_edge_to_cpu: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE18
		frame_hdr.valid && is_flood && edge_variant && pvlan_on
		|=> decision.to_cpu && decision.egress == '0)
		else $error("edge flood not handed to software");

	a_isolated_scope: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE12
		frame_hdr.valid && is_flood && !edge_variant && eff_class[frame_hdr.in_port] == PC_ISOLATED
		|=> (decision.egress & ~prev_primary) == '0)
		else $error("isolated flood left primary ports");

	a_outside_block: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE15
		frame_hdr.valid && frame_hdr.bcast && !admit_bcast && !edge_variant &&
		eff_class[frame_hdr.in_port] inside {PC_PRIMARY, PC_NONE}
		|=> (decision.egress & prev_member) == '0)
		else $error("outside broadcast entered private group");

	a_known_unicast: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE22
		frame_hdr.valid && !is_flood && frame_hdr.known_port != frame_hdr.in_port &&
		32'(frame_hdr.known_port) < NUM_PORTS
		|=> decision.egress == (MAX_PORTS'(1) << $past(frame_hdr.known_port)) && !decision.to_cpu)
		else $error("known unicast not sent to learned port");

	a_untagged_keep: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
		frame_hdr.valid && !port_tagged[frame_hdr.in_port] |=> !decision.strip_outer)
		else $error("untagged ingress had tag stripped");

	a_strip_pushes: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
		decision.strip_outer |-> decision.push_outer && decision.outer_tag == $past(tag_table[uplink_port]))
		else $error("strip without uplink tag push");

	a_dual_refused: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE21
		|dual_claim |=> (member_reject & $past(dual_claim)) == $past(dual_claim))
		else $error("dual mode port accepted as member");

	a_edge_refused: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE19
		|edge_claim |=> (member_reject & $past(edge_claim)) == $past(edge_claim))
		else $error("tagged port accepted as member on edge variant");

	a_reset_state: assert property (@(posedge core_clk) // RULE5
		!rst_b |=> tag_table[0] == TAG_RESET && tag_table[MAX_PORTS-1] == TAG_RESET &&
		member_reject == '0 && !decision.valid && decision.egress == '0)
		else $error("reset state wrong");

	a_per20_group: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
		tag_cfg.valid && !tag_cfg.clear && tag_gran == GRAN_PER_20
		|=> tag_table[0] == $past(tag_cfg.tag) && tag_table[NUM_PORTS-1] == $past(tag_cfg.tag))
		else $error("twenty port group write wrong extent");

	a_per_port_only: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
		tag_cfg.valid && !tag_cfg.all_ports && tag_gran == GRAN_PER_PORT && tag_cfg.port != 4'h0 &&
		!trunk_member[0] |=> tag_table[0] == $past(tag_table[0]))
		else $error("per port write reached another port");

	a_member_to_primary: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE12 RULE13
		frame_hdr.valid && is_flood && !edge_variant &&
		eff_class[frame_hdr.in_port] inside {PC_ISOLATED, PC_COMMUNITY}
		|=> (decision.egress & $past(to_primary)) == $past(to_primary))
		else $error("member flood missed a mapped primary");

	a_community_peer: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
		frame_hdr.valid && is_flood && !edge_variant && eff_class[frame_hdr.in_port] == PC_COMMUNITY
		|=> (decision.egress & $past(peer_mask)) == $past(peer_mask))
		else $error("community flood missed a peer");

	a_primary_reach: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE14
		frame_hdr.valid && is_flood && !edge_variant && eff_class[frame_hdr.in_port] == PC_PRIMARY &&
		(frame_hdr.unknown_uc ? admit_uu : admit_bcast)
		|=> (decision.egress & $past(reach_mask)) == $past(reach_mask))
		else $error("admitted primary flood missed a member");

	a_cpu_off_edge: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE18
		frame_hdr.valid && !edge_variant |=> !decision.to_cpu)
		else $error("frame handed to software outside edge variant");

	a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE22
		!frame_hdr.valid |=> !decision.valid && decision.egress == '0 && !decision.to_cpu)
		else $error("decision without a frame");

	a_tag_mismatch: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE23
		frame_hdr.valid && frame_hdr.type_field != tag_table[frame_hdr.in_port] |=> !decision.strip_outer)
		else $error("foreign tag type stripped");

	a_match_strips: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE10
		frame_hdr.valid && port_tagged[frame_hdr.in_port] &&
		frame_hdr.type_field == tag_table[frame_hdr.in_port]
		|=> decision.strip_outer == decision.push_outer)
		else $error("matching tag not translated");

	a_push_uplink: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
		decision.push_outer |-> decision.egress[uplink_port])
		else $error("outer tag pushed on frame not sent to uplink");

	c_community_flood: cover property (@(posedge core_clk) disable iff (!rst_b)
		frame_hdr.valid && frame_hdr.bcast && eff_class[frame_hdr.in_port] == PC_COMMUNITY);
	c_translate: cover property (@(posedge core_clk) disable iff (!rst_b)
		decision.strip_outer);
	c_double_tag: cover property (@(posedge core_clk) disable iff (!rst_b)
		decision.push_outer && !decision.strip_outer);
	c_edge_cpu: cover property (@(posedge core_clk) disable iff (!rst_b)
		decision.to_cpu);
	c_admitted_flood: cover property (@(posedge core_clk) disable iff (!rst_b)
		frame_hdr.valid && frame_hdr.bcast && admit_bcast && eff_class[frame_hdr.in_port] == PC_PRIMARY);

endmodule

// ==== verification/neighbour_port.sv ====
`timescale 1ns/1ps
// Far-side switch: offers one frame header per call, valid for one cycle.
module neighbour_port (
	input  wire logic                   core_clk,  // Switch clock.
	output vlan_filter_pkg::frame_hdr_t frame_hdr  // Header toward the block.
);
	import vlan_filter_pkg::*;
	initial frame_hdr = '0;
	// Kind 0 is known unicast, 1 broadcast, 2 unknown unicast, 3 unknown multicast.
	task automatic send(input logic [3:0] in_p, input logic [15:0] tf, input int kind, input logic [3:0] kp);
		@(posedge core_clk);
		#2;
		frame_hdr = '{1'b1, in_p, tf, kind == 1, kind == 2, kind == 3, kp};
		@(posedge core_clk);
		#2;
		// Released fields flip, so a stale header can never pass for a fresh one.
		frame_hdr = {1'b0, ~frame_hdr[$bits(frame_hdr)-2:0]};
	endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import vlan_filter_pkg::*;
	logic                              core_clk     = 1'b0;
	logic                              rst_b        = 1'b0;
	tag_gran_t                         tag_gran     = GRAN_PER_PORT;
	tag_cfg_t                          tag_cfg      = '0;
	logic [MAX_PORTS-1:0]              trunk_member = '0;
	logic [MAX_PORTS-1:0]              port_tagged  = '0;
	logic [MAX_PORTS-1:0]              dual_mode    = '0;
	logic [PORT_W-1:0]                 uplink_port  = 4'hf;
	port_class_t [MAX_PORTS-1:0]       port_class;
	logic [MAX_PORTS-1:0][SEC_W-1:0]   sec_group    = '0;
	logic [NUM_SEC-1:0][MAX_PORTS-1:0] sec_map      = '0;
	logic                              admit_bcast  = 1'b0;
	logic                              admit_uu     = 1'b0;
	logic                              edge_variant = 1'b0;
	frame_hdr_t                        frame_hdr;
	logic [MAX_PORTS-1:0][TAG_W-1:0]   tag_table;
	logic [MAX_PORTS-1:0]              member_reject;
	fwd_decision_t                     decision;
	int                                n_fail       = 0;
	int                                n_checks     = 0;

	always #12.5 core_clk = ~core_clk;

	vlan_tag_pvlan_filter #(.NUM_PORTS(16)) dut (.core_clk(core_clk), .rst_b(rst_b), .tag_gran(tag_gran),
		.tag_cfg(tag_cfg), .trunk_member(trunk_member), .port_tagged(port_tagged), .dual_mode(dual_mode),
		.uplink_port(uplink_port), .port_class(port_class), .sec_group(sec_group), .sec_map(sec_map),
		.admit_bcast(admit_bcast), .admit_uu(admit_uu), .edge_variant(edge_variant), .frame_hdr(frame_hdr),
		.tag_table(tag_table), .member_reject(member_reject), .decision(decision));

	neighbour_port nb (.core_clk(core_clk), .frame_hdr(frame_hdr));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cfg(input logic clr, input logic all, input logic [3:0] p, input logic [15:0] t);
		@(posedge core_clk);
		#2;
		tag_cfg = '{1'b1, clr, all, p, t};
		@(posedge core_clk);
		#2;
		tag_cfg = '{1'b0, ~clr, ~all, ~p, ~t};
	endtask

	task automatic tab(input int a, input int b, input logic [15:0] t_in, input logic [15:0] t_out);
		for (int i = 0; i < 16; i++) chk(tag_table[i], (i >= a && i <= b) ? t_in : t_out);
	endtask

	task automatic fl(input logic [3:0] in_p, input int kind, input logic [3:0] kp, input logic [15:0] eg);
		nb.send(in_p, 16'h8100, kind, kp);
		chk(decision.valid, 1'b1);
		chk(decision.to_cpu, 1'b0);
		chk(decision.egress, eg);
	endtask

	task automatic xl(input logic [15:0] tf, input logic [3:0] kp, input logic push, input logic strip);
		nb.send(4'h0, tf, 0, kp);
		chk(decision.push_outer, push);
		chk(decision.strip_outer, strip);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		tab(0, 15, 16'h8100, 16'h8100);
		chk(decision.valid, 1'b0);
		chk(decision.egress, 16'h0000);
	endtask

	task automatic t_groups;
		tag_gran = GRAN_PER_10;
		cfg(1'b0, 1'b0, 4'h3, 16'h9100);
		tab(0, 9, 16'h9100, 16'h8100);
		cfg(1'b1, 1'b0, 4'h5, 16'h1234);
		tab(0, 15, 16'h8100, 16'h8100);
		tag_gran = GRAN_PER_20;
		cfg(1'b0, 1'b0, 4'hf, 16'h5100);
		tab(0, 15, 16'h5100, 16'h5100);
		tag_gran = GRAN_PER_PORT;
		cfg(1'b0, 1'b1, 4'h0, 16'h0000);
		tab(0, 15, 16'h0000, 16'h0000);
		cfg(1'b0, 1'b0, 4'hc, 16'hffff);
		tab(12, 12, 16'hffff, 16'h0000);
	endtask

	task automatic t_trunk;
		trunk_member = 16'hc010;
		cfg(1'b0, 1'b0, 4'h4, 16'h9100);
		chk(tag_table[14], 16'h9100);
		chk(tag_table[15], 16'h9100);
		chk(tag_table[4], 16'h9100);
		chk(tag_table[13], 16'h0000);
		trunk_member = '0;
		cfg(1'b1, 1'b1, 4'h0, 16'h0000);
		tab(0, 15, 16'h8100, 16'h8100);
		cfg(1'b0, 1'b0, 4'hf, 16'h9100);
	endtask

	task automatic t_flood;
		port_class[2] = PC_PRIMARY;
		port_class[3] = PC_PRIMARY;
		port_class[5] = PC_COMMUNITY;
		port_class[6] = PC_COMMUNITY;
		port_class[9] = PC_ISOLATED;
		port_class[10] = PC_ISOLATED;
		sec_group[5] = 2'h2;
		sec_group[6] = 2'h2;
		sec_group[9] = 2'h1;
		sec_group[10] = 2'h1;
		sec_map[1] = 16'h000c;
		sec_map[2] = 16'h0004;
		fl(4'h9, 1, 4'h0, 16'h000c);
		fl(4'h5, 1, 4'h0, 16'h0044);
		fl(4'h2, 1, 4'h0, 16'hf99b);
		admit_bcast = 1'b1;
		fl(4'h2, 1, 4'h0, 16'hfffb);
		fl(4'h2, 2, 4'h0, 16'hf99b);
		admit_bcast = 1'b0;
		admit_uu = 1'b1;
		fl(4'h3, 2, 4'h0, 16'hff97);
		fl(4'h3, 3, 4'h0, 16'hf997);
		admit_uu = 1'b0;
		fl(4'h0, 1, 4'h0, 16'hf99e);
		fl(4'h9, 0, 4'ha, 16'h0400);
	endtask

	task automatic t_reject;
		dual_mode[9] = 1'b1;
		@(posedge core_clk);
		#2;
		chk(member_reject[9], 1'b1);
		fl(4'h0, 1, 4'h0, 16'hfb9e);
		dual_mode = '0;
		edge_variant = 1'b1;
		port_tagged[5] = 1'b1;
		@(posedge core_clk);
		#2;
		chk(member_reject, 16'h0020);
		nb.send(4'h1, 16'h8100, 1, 4'h0);
		chk(decision.to_cpu, 1'b1);
		chk(decision.egress, 16'h0000);
		edge_variant = 1'b0;
		port_tagged = '0;
	endtask

	task automatic t_xlate;
		port_tagged[0] = 1'b1;
		xl(16'h8100, 4'hf, 1'b1, 1'b1);
		chk(decision.outer_tag, 16'h9100);
		chk(decision.ingress_tag, 16'h8100);
		xl(16'h8500, 4'hf, 1'b1, 1'b0);
		port_tagged[0] = 1'b0;
		xl(16'h8100, 4'hf, 1'b1, 1'b0);
		xl(16'h8100, 4'h1, 1'b0, 1'b0);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		for (int i = 0; i < MAX_PORTS; i++) port_class[i] = PC_NONE;
		repeat (5) @(posedge core_clk);
		#2;
		rst_b = 1'b1;
		t_reset();
		t_groups();
		t_trunk();
		t_flood();
		t_reject();
		t_xlate();
		finish_test();
	end

	// The scenarios need well under 200 cycles; this span allows ten times that.
	initial begin
		#50000;
		n_fail++;
		finish_test();
	end
endmodule
